// ---- rtl/mitc_ctrl.sv ----
// interrupt request, acceptance and time-base logic of the controller.
// assumes the core samples the take pulse at an instruction boundary,
// pushes its next address and jumps to the vector given with it.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module mitc_ctrl
    import mitc_pkg::*;
(
    // clock, reset, freeze
    input  wire logic                 core_clk,
    input  wire logic                 resetn,
    input  wire logic                 ce,
    // register bus
    input  wire logic [7:0]           address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [31:0]          writedata,
    input  wire logic [3:0]           byteenable,
    output logic [31:0]               readdata,
    output logic                      waitrequest,
    // event sources
    input  wire logic [NUM_EXT-1:0]   ext_irq_pins,
    input  wire logic                 conv_done,
    input  wire logic                 overvolt_protect,
    input  wire logic                 sub_clock,
    // core side
    input  wire logic                 core_ready,
    input  wire logic                 stack_full,
    input  wire logic                 return_from_irq_instr,
    output mitc_core_out_t            core_out,
    output logic                      wake
);
    // ********************************************************************
    // state
    // ********************************************************************
    mitc_state_t s;
    mitc_state_t next_s;

    logic [NUM_EXT-1:0]  ext_edge;
    logic [NUM_TICK-1:0] tick_ovf;
    logic [NUM_SRC-1:0]  events;
    logic [NUM_SRC-1:0]  cand;
    logic                psc_tick;
    logic                wr_go;
    logic                accept;
    logic [2:0]          pick;
    logic [31:0]         rd_mux;

    // bus answers after one wait cycle
    assign waitrequest = !s.ack;
    assign readdata    = s.rdata;
    assign wr_go       = write && s.ack && byteenable[0];
    // take is shown once per enabled cycle only
    assign core_out.take   = s.core.take && ce;
    assign core_out.vector = s.core.vector;
    assign core_out.pop    = s.core.pop && ce;
    // any set flag wakes the device, enabled or not
    assign wake = |s.flags;

    // ********************************************************************
    // external pin edge detectors
    // ********************************************************************
    // pull-high control sits in the port logic and is not touched here
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
            logic [1:0] sel;
            logic       armed;
            logic       rise;
            logic       fall;
            assign sel   = s.edge_sel[2*gi +: 2];
            // pin acts only when enabled, selected and set as input
            assign armed = s.en[gi] && s.pin_cfg[gi]
                           && s.pin_cfg[PINCFG_DIR + gi];
            assign rise  = ext_irq_pins[gi] && !s.pin_prev[gi];
            assign fall  = !ext_irq_pins[gi] && s.pin_prev[gi];
            // edge select, off setting never triggers
            assign ext_edge[gi] = armed
                && (((sel == EDGE_RISE) && rise)
                 || ((sel == EDGE_FALL) && fall)
                 || ((sel == EDGE_BOTH) && (rise || fall)));
        end
    endgenerate

    // ********************************************************************
    // time-base units
    // ********************************************************************
    // prescaler clock from system, system/4 or sub-clock rising edges
    always_comb begin
        case (s.psc_sel)
            PSC_SYS:      psc_tick = 1'b1;
            PSC_SYS_DIV4: psc_tick = (s.div4 == DIV4_LAST);
            default:      psc_tick = sub_clock && !s.sub_prev;
        endcase
    end

    generate
        for (gi = 0; gi < NUM_TICK; gi++) begin : g_tick
            logic [PSC_CNT_W-1:0] mask;
            // low 8+period bits of the shared count all ones = overflow
            assign mask = ~({PSC_CNT_W{1'b1}}
                          << (TICK_MIN_EXP + {1'b0, s.tick_per[gi]}));
            assign tick_ovf[gi] = s.tick_on[gi] && psc_tick
                && ((s.psc_cnt & mask) == mask);
        end
    endgenerate

    // ********************************************************************
    // event collection and priority pick
    // ********************************************************************
    assign events = {tick_ovf, overvolt_protect, conv_done, ext_edge};
    // only enabled flags compete, disabled ones just wait
    assign cand   = s.flags & s.en;
    // global enable, stack room and a core boundary are all needed
    assign accept = s.gie && !stack_full && core_ready
                    && (|cand);

    // lowest index wins, which is also the lowest vector
    always_comb begin
        pick = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (cand[i]) begin
                pick = 3'(i);
            end
        end
    end

    // ********************************************************************
    // register read mux
    // ********************************************************************
    always_comb begin
        rd_mux = 32'h00000000;
        case (address)
            OFF_GLOBAL:  rd_mux[0]   = s.gie;
            OFF_FLAGS:   rd_mux[7:0] = s.flags;
            OFF_ENABLES: rd_mux[7:0] = s.en;
            OFF_EDGE:    rd_mux[7:0] = s.edge_sel;
            OFF_PINCFG:  rd_mux[7:0] = s.pin_cfg;
            // upper bits stay zero
            OFF_PSC:     rd_mux[1:0] = s.psc_sel;
            OFF_TICK0: begin
                rd_mux[TICK_ON]          = s.tick_on[0];
                rd_mux[TICK_PER_W-1:0]   = s.tick_per[0];
            end
            OFF_TICK1: begin
                rd_mux[TICK_ON]          = s.tick_on[1];
                rd_mux[TICK_PER_W-1:0]   = s.tick_per[1];
            end
            default:     rd_mux = 32'h00000000;
        endcase
    end

    // ********************************************************************
    // next state
    // ********************************************************************
    always_comb begin
        next_s = s;
        next_s.pin_prev  = ext_irq_pins;
        next_s.sub_prev  = sub_clock;
        next_s.div4      = s.div4 + 2'h1;
        next_s.core.take = 1'b0;
        next_s.core.pop  = 1'b0;
        if (psc_tick) begin
            next_s.psc_cnt = s.psc_cnt + 1'b1;
        end
        // bus handshake: one wait cycle, data captured on the way in
        if ((read || write) && !s.ack) begin
            next_s.ack   = 1'b1;
            next_s.rdata = rd_mux;
        end else begin
            next_s.ack   = 1'b0;
        end
        // register writes take effect when waitrequest is low and byteenable[0] is set
        if (wr_go) begin
            case (address)
                OFF_GLOBAL:  next_s.gie      = writedata[0];
                OFF_FLAGS:   next_s.flags    = writedata[7:0];
                OFF_ENABLES: next_s.en       = writedata[7:0];
                OFF_EDGE:    next_s.edge_sel = writedata[7:0];
                OFF_PINCFG:  next_s.pin_cfg  = writedata[7:0];
                OFF_PSC:     next_s.psc_sel  = writedata[1:0];
                OFF_TICK0: begin
                    next_s.tick_on[0]  = writedata[TICK_ON];
                    next_s.tick_per[0] = writedata[TICK_PER_W-1:0];
                end
                OFF_TICK1: begin
                    next_s.tick_on[1]  = writedata[TICK_ON];
                    next_s.tick_per[1] = writedata[TICK_PER_W-1:0];
                end
                default: ;
            endcase
        end
        // acceptance: vector, serviced flag and global enable together
        if (accept) begin
            next_s.core.take   = 1'b1;
            next_s.core.vector = VEC_BASE + 12'(pick) * VEC_STEP;
            next_s.idx         = pick;
            next_s.gie         = 1'b0;
            next_s.flags[pick] = 1'b0;
        end
        // return instruction pops the saved address
        if (return_from_irq_instr) begin
            next_s.core.pop = 1'b1;
        end
        // events set flags whatever the enables, pin edges only when enabled; set beats any clear
        next_s.flags = next_s.flags | events;
    end

    // ********************************************************************
    // state register
    // ********************************************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // ********************************************************************
    // checks
    // ********************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence bus_wait;
        (read || write) && !s.ack && ce;
    endsequence
    sequence psc_read;
        read && s.ack && (address == OFF_PSC);
    endsequence

    gie_block_a: assert property (ce && !s.gie |=> !s.core.take)
        else $error("take issued with global enable low");
    stack_hold_a: assert property (ce && stack_full |=> !s.core.take)
        else $error("take issued with stack full");
    gie_clear_a: assert property (s.core.take |-> !s.gie)
        else $error("global enable still set at take");
    take_enabled_a: assert property (
        ce ##1 s.core.take |-> $past(cand[pick]))
        else $error("take for a source that was not enabled and set");
    vector_map_a: assert property (s.core.take |->
        s.core.vector == VEC_BASE + 12'(s.idx) * VEC_STEP)
        else $error("vector does not match picked source");
    flag_keep_a: assert property (ce && !wr_go && !accept |=>
        ((s.flags & $past(s.flags)) == $past(s.flags)))
        else $error("flag lost without service or write");
    ext_edge_a: assert property (ce && ext_edge[0] |=> s.flags[0])
        else $error("external edge did not set its flag");
    tick_set_a: assert property (ce && tick_ovf[0] |=> s.flags[SRC_TICK0])
        else $error("time-base overflow did not set its flag");
    bus_answer_a: assert property (bus_wait |=> !waitrequest)
        else $error("bus answer not given after one wait cycle");
    psc_zero_a: assert property (psc_read |-> readdata[31:2] == 30'h0)
        else $error("prescaler select upper bits not zero");
    wake_flag_a: assert property (ce && (|events) |=> wake)
        else $error("event did not raise wake");

    // wake drops only when every flag is clear
    wake_clear_a: assert property (s.flags == 8'h00 |-> !wake)
        else $error("wake high with no flag set");

    // a return instruction is answered by a pop one cycle later
    pop_follow_a: assert property (
        ce && return_from_irq_instr |=> s.core.pop)
        else $error("return did not produce a pop");

    // take lasts exactly one enabled cycle
    take_pulse_a: assert property (ce && s.core.take |=> !s.core.take)
        else $error("take held for more than one cycle");

    // acceptance clears the global enable in the same step
    gie_drop_a: assert property (ce && accept |=> !s.gie)
        else $error("global enable survived acceptance");

    // serviced flag is gone unless a new event set it again
    flag_clear_a: assert property (
        ce && accept && !events[pick] |=> !s.flags[s.idx])
        else $error("serviced flag not cleared");

    // nothing enabled and pending means no take
    no_cand_a: assert property (ce && !(|cand) |=> !s.core.take)
        else $error("take with no enabled pending source");

    // acceptance waits for a core instruction boundary
    core_gate_a: assert property (ce && !core_ready |=> !s.core.take)
        else $error("take issued off an instruction boundary");

    // conversion end and over-voltage set their flags
    conv_set_a: assert property (ce && conv_done |=> s.flags[SRC_CONV])
        else $error("conversion end did not set its flag");
    ovp_set_a: assert property (
        ce && overvolt_protect |=> s.flags[SRC_OVP])
        else $error("over-voltage did not set its flag");

    // second time base sets the flag just above the first
    tick1_set_a: assert property (
        ce && tick_ovf[1] |=> s.flags[SRC_TICK0 + 1])
        else $error("second time-base overflow did not set its flag");

    // the picked source is pending and no lower one is
    pick_low_a: assert property (accept |-> cand[pick]
        && ((cand & ((8'h01 << pick) - 8'h01)) == 8'h00))
        else $error("pick is not the lowest pending source");

    // system clock selection ticks the prescaler every cycle
    psc_sys_a: assert property (s.psc_sel == PSC_SYS |-> psc_tick)
        else $error("prescaler idle with system clock selected");

    // a low clock enable freezes all state
    freeze_a: assert property (!ce |=> $stable(s))
        else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// ---- shared/mitc_pkg.sv ----
// constants, field layout and carrier types of the interrupt and time-base
// controller; assumes a byte-addressed 32-bit register bus.
package mitc_pkg;
    // ********************************************************************
    // register byte offsets
    // ********************************************************************
    localparam logic [7:0] OFF_GLOBAL  = 8'h00;
    localparam logic [7:0] OFF_FLAGS   = 8'h04;
    localparam logic [7:0] OFF_ENABLES = 8'h08;
    localparam logic [7:0] OFF_EDGE    = 8'h0c;
    localparam logic [7:0] OFF_PINCFG  = 8'h10;
    localparam logic [7:0] OFF_PSC     = 8'h14;
    localparam logic [7:0] OFF_TICK0   = 8'h18;
    localparam logic [7:0] OFF_TICK1   = 8'h1c;
    // ********************************************************************
    // source positions in the flag and enable registers
    // ********************************************************************
    localparam int NUM_SRC   = 8;
    localparam int NUM_EXT   = 4;
    localparam int NUM_TICK  = 2;
    localparam int SRC_CONV  = 4;
    localparam int SRC_OVP   = 5;
    localparam int SRC_TICK0 = 6;
    // pin configuration: function select low nibble, input direction high
    localparam int PINCFG_DIR = 4;
    // tick control: on bit and period field
    localparam int TICK_ON    = 7;
    localparam int TICK_PER_W = 3;
    // ********************************************************************
    // codes, reset values and timing
    // ********************************************************************
    localparam logic [1:0] EDGE_OFF     = 2'h0;
    localparam logic [1:0] EDGE_RISE    = 2'h1;
    localparam logic [1:0] EDGE_FALL    = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;
    localparam logic [1:0] PSC_SYS      = 2'h0;
    localparam logic [1:0] PSC_SYS_DIV4 = 2'h1;
    localparam logic [1:0] DIV4_LAST    = 2'h3;
    localparam logic [3:0] TICK_MIN_EXP = 4'h8;
    localparam int         PSC_CNT_W    = 15;
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [11:0] VEC_BASE    = 12'h004;
    localparam logic [11:0] VEC_STEP    = 12'h004;
    // ********************************************************************
    // carriers
    // ********************************************************************
    typedef struct packed {
        logic        take;
        logic [11:0] vector;
        logic        pop;
    } mitc_core_out_t;
    typedef struct packed {
        logic                 gie;
        logic [NUM_SRC-1:0]   flags;
        logic [NUM_SRC-1:0]   en;
        logic [7:0]           edge_sel;
        logic [7:0]           pin_cfg;
        logic [1:0]           psc_sel;
        logic [NUM_TICK-1:0]  tick_on;
        logic [NUM_TICK-1:0][TICK_PER_W-1:0] tick_per;
        logic [NUM_EXT-1:0]   pin_prev;
        logic                 sub_prev;
        logic [1:0]           div4;
        logic [PSC_CNT_W-1:0] psc_cnt;
        logic                 ack;
        logic [31:0]          rdata;
        mitc_core_out_t       core;
        logic [2:0]           idx;
    } mitc_state_t;
endpackage

// ---- bench/mitc_core_model.sv ----
// core-side partner: program sequencer and a small return-address stack.
// assumes the controller's take and pop pulses last one cycle each.
`timescale 1ns/100ps
`default_nettype none
module mitc_core_model
    import mitc_pkg::*;
#(
    parameter int DEPTH = 1
)
(
    // clock and reset
    input  wire logic           core_clk,
    input  wire logic           resetn,
    // bench controls
    input  wire logic           slow,
    input  wire logic           ret_req,
    // controller side
    input  wire mitc_core_out_t core_out,
    output logic                core_ready,
    output logic                stack_full,
    output logic                return_from_irq_instr
);
    // ****************************************************************
    // stack
    // ****************************************************************
    int   depth;
    logic phase;
    // push on take, pop on the pop pulse, return issued a cycle later
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            depth <= 0;
            phase <= 1'b0;
            return_from_irq_instr <= 1'b0;
        end else begin
            phase <= !phase;
            return_from_irq_instr <= ret_req;
            depth <= depth + int'(core_out.take) - int'(core_out.pop);
        end
    end
    // a slow core reaches an instruction boundary every other cycle
    assign core_ready = !slow || phase;
    assign stack_full = (depth >= DEPTH);
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench of the interrupt and time-base controller.
// assumes one 100 MHz clock and the core model as far side.
`timescale 1ns/100ps
`default_nettype none
module tb
    import mitc_pkg::*;
;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic core_clk, resetn, read, write, conv_done, overvolt_protect;
    logic sub_clock, core_ready, stack_full, return_from_irq_instr;
    logic wake, slow, ret_req, pend, ce;
    logic [7:0] address;
    logic [31:0] writedata, readdata, r;
    logic [3:0] byteenable, ext_irq_pins;
    logic waitrequest;
    mitc_core_out_t core_out;
    logic [31:0] exp_q[$];
    int fails, compares, cyc, t_take, t_prev, sub_div;
    int psc_t[4] = '{0, 0, 1, 3};
    int per_t[4] = '{0, 1, 0, 0};
    int span_t[4] = '{256, 512, 1024, 1536};
    mitc_ctrl dut_u (.core_clk(core_clk), .resetn(resetn), .ce(ce),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .ext_irq_pins(ext_irq_pins), .conv_done(conv_done),
        .overvolt_protect(overvolt_protect), .sub_clock(sub_clock),
        .core_ready(core_ready), .stack_full(stack_full),
        .return_from_irq_instr(return_from_irq_instr),
        .core_out(core_out), .wake(wake));
    mitc_core_model #(.DEPTH(1)) core_u (.core_clk(core_clk),
        .resetn(resetn), .slow(slow), .ret_req(ret_req),
        .core_out(core_out), .core_ready(core_ready),
        .stack_full(stack_full),
        .return_from_irq_instr(return_from_irq_instr));
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        do begin
            @(posedge core_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        check("bus answer", 1, n < 50);
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(nm, e, q);
    endtask
    // 0 conversion end, 1 over-voltage, other return request
    task automatic pulse(input int w);
        @(posedge core_clk);
        case (w)
            0: conv_done <= 1'b1;
            1: overvolt_protect <= 1'b1;
            default: ret_req <= 1'b1;
        endcase
        @(posedge core_clk);
        {conv_done, overvolt_protect, ret_req} <= 3'h0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 5000 && exp_q.size() != 0; n++) @(posedge core_clk);
        check("take came", 0, exp_q.size());
    endtask
    // reference priority: lowest pending enabled index wins
    function automatic logic [31:0] vec(input logic [7:0] f);
        for (int i = 0; i < 8; i++)
            if (f[i]) return 32'(VEC_BASE) + 32'(VEC_STEP) * i;
        return 32'h0;
    endfunction
    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ****************************************************************
    // clock, sub clock, monitor, watchdog
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // sub clock rises every six system cycles
    always @(posedge core_clk) begin
        sub_div <= (sub_div == 2) ? 0 : sub_div + 1;
        if (sub_div == 2) sub_clock <= !sub_clock;
    end
    // compare every take with the reference queue and check a pop after each return
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (pend) check("pop", 1, core_out.pop);
        pend <= return_from_irq_instr;
        if (core_out.take === 1'b1) begin
            t_prev <= t_take;
            t_take <= cyc;
            if (exp_q.size() == 0) check("stray take", 0, 1);
            else check("vector", exp_q.pop_front(), {20'h0, core_out.vector});
        end
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        check("watchdog", 0, 1);
        complete_run();
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        {resetn, read, write, conv_done, overvolt_protect} = 5'h0;
        {sub_clock, slow, ret_req, pend} = 4'h0;
        {address, writedata, ext_irq_pins} = '0;
        byteenable = 4'h1;
        ce = 1'b1;
        {fails, compares, cyc, t_take, t_prev, sub_div} = '0;
        void'($urandom(35));
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        rd_chk("psc reset", OFF_PSC, 32'h0);
        r = $urandom;
        wr(OFF_PSC, r);
        rd_chk("psc bits", OFF_PSC, r & 32'h3);
        byteenable <= 4'h0;
        wr(OFF_PSC, ~r);
        byteenable <= 4'h1;
        rd_chk("psc kept", OFF_PSC, r & 32'h3);
        rd_chk("unmapped", 8'h20, 32'h0);
        wr(OFF_GLOBAL, 32'h1);
        pulse(0);
        rd_chk("disabled flag", OFF_FLAGS, 32'h10);
        check("wake", 1, wake);
        wr(OFF_GLOBAL, 32'h0);
        wr(OFF_ENABLES, 32'h30);
        pulse(1);
        rd_chk("blocked flags", OFF_FLAGS, 32'h30);
        slow <= 1'b1;
        exp_q.push_back(vec(8'h30));
        wr(OFF_GLOBAL, 32'h1);
        wait_idle();
        rd_chk("gie cleared", OFF_GLOBAL, 32'h0);
        rd_chk("served flag", OFF_FLAGS, 32'h20);
        exp_q.push_back(vec(8'h20));
        wr(OFF_GLOBAL, 32'h1);
        repeat (20) @(posedge core_clk);
        rd_chk("held off", OFF_FLAGS, 32'h20);
        pulse(2);
        wait_idle();
        pulse(2);
        slow <= 1'b0;
        wr(OFF_ENABLES, 32'h0f);
        for (int c = 0; c < 5; c++) begin
            logic [1:0] e;
            e = (c < 4) ? 2'(c) : EDGE_BOTH;
            wr(OFF_PINCFG, (c < 4) ? 32'hff : 32'h0f);
            wr(OFF_EDGE, {24'h0, {4{e}}});
            wr(OFF_FLAGS, 32'h0);
            r = $urandom;
            ext_irq_pins <= r[3:0];
            rd_chk("rise", OFF_FLAGS, (c < 4 && e[0]) ? r & 32'hf : 0);
            wr(OFF_FLAGS, 32'h0);
            ext_irq_pins <= 4'h0;
            rd_chk("fall", OFF_FLAGS, (c < 4 && e[1]) ? r & 32'hf : 0);
        end
        wr(OFF_FLAGS, 32'h0);
        @(posedge core_clk);
        check("wake idle", 0, wake);
        // a frozen controller drops the event
        ce <= 1'b0;
        pulse(0);
        ce <= 1'b1;
        rd_chk("frozen", OFF_FLAGS, 32'h0);
        wr(OFF_FLAGS, 32'h10);
        @(posedge core_clk);
        check("wake set", 1, wake);
        wr(OFF_FLAGS, 32'h0);
        wr(OFF_ENABLES, 32'h40);
        for (int i = 0; i < 4; i++) begin
            wr(OFF_PSC, psc_t[i]);
            wr(OFF_TICK0, 32'h80 | per_t[i]);
            for (int k = 0; k < 3; k++) begin
                exp_q.push_back(vec(8'h40));
                wr(OFF_GLOBAL, 32'h1);
                wait_idle();
                pulse(2);
            end
            check("period", span_t[i], t_take - t_prev);
            wr(OFF_TICK0, 32'h0);
        end
        complete_run();
    end
endmodule
`default_nettype wire
